// ---- rtl/bfrm_defs.svh ----
// constants of the burner fieldbus register map
`ifndef BFRM_DEFS_SVH
`define BFRM_DEFS_SVH

// ****************************************
// word addresses
// ****************************************
`define BFRM_ADDR_FIRST       8'h29
`define BFRM_ADDR_UNIT_ART_UP 8'h29
`define BFRM_ADDR_SW_ART_LO   8'h2a
`define BFRM_ADDR_SW_ART_HI   8'h2b
`define BFRM_ADDR_PROD_DM     8'h2c
`define BFRM_ADDR_PROD_YEAR   8'h2d
`define BFRM_ADDR_SERIAL_LO   8'h2e
`define BFRM_ADDR_SERIAL_HI   8'h2f
`define BFRM_ADDR_HW_ART_LO   8'h30
`define BFRM_ADDR_HW_ART_HI   8'h31
`define BFRM_ADDR_UN_ART_LO   8'h32
`define BFRM_ADDR_UN_ART_HI   8'h33
`define BFRM_ADDR_ERR_INFO4   8'h34
`define BFRM_ADDR_ERR_STATE   8'h35
`define BFRM_ADDR_STATUS      8'h36
`define BFRM_ADDR_TEMP        8'h37
`define BFRM_ADDR_CYCLE_LO    8'h38
`define BFRM_ADDR_CYCLE_HI    8'h39
`define BFRM_ADDR_RSVD        8'h3a
`define BFRM_ADDR_LAST        8'h3a
`define BFRM_NUM_WORDS        18

// ****************************************
// field layout
// ****************************************
`define BFRM_STATUS_BITS      12
`define BFRM_TEMP_BIAS        8'h32

// ****************************************
// serial link settings
// ****************************************
`define BFRM_FC_SET_BAUD      8'h41
`define BFRM_CLK_HZ           40000000
`define BFRM_BAUD_9600        9600
`define BFRM_BAUD_19200       19200
`define BFRM_BAUD_57600       57600
`define BFRM_DIV_W            16
`define BFRM_DP_SPEED_COUNT   4'ha

`endif

// ---- rtl/bfrm_pkg.sv ----
// types of the burner fieldbus register map
package bfrm_pkg;

  typedef enum logic [1:0] {
    BFRM_BAUD_9600  = 2'b00,
    BFRM_BAUD_19200 = 2'b01,
    BFRM_BAUD_57600 = 2'b10
  } bfrm_baud_t;

  typedef enum logic [1:0] {
    BFRM_PAR_NONE = 2'b00,
    BFRM_PAR_EVEN = 2'b01,
    BFRM_PAR_ODD  = 2'b10
  } bfrm_parity_t;

  // 9.6 .. 12000 kbit/s in ascending order
  typedef enum logic [3:0] {
    BFRM_DP_9K6   = 4'h0,
    BFRM_DP_19K2  = 4'h1,
    BFRM_DP_45K45 = 4'h2,
    BFRM_DP_93K75 = 4'h3,
    BFRM_DP_187K5 = 4'h4,
    BFRM_DP_500K  = 4'h5,
    BFRM_DP_1M5   = 4'h6,
    BFRM_DP_3M    = 4'h7,
    BFRM_DP_6M    = 4'h8,
    BFRM_DP_12M   = 4'h9
  } bfrm_dp_speed_t;

endpackage : bfrm_pkg

// ---- rtl/bfrm_regmap.sv ----
// read-only fieldbus word map 41..58 and serial link settings
`include "bfrm_defs.svh"

module bfrm_regmap (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // word read port
  input  wire logic        rd_req,
  input  wire logic [7:0]  rd_addr,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output logic             rd_err,
  input  wire logic        wr_req,
  output logic             wr_refused,
  // identity data, same clock
  input  wire logic [7:0]  unit_article_msb,
  input  wire logic [7:0]  unit_article_index,
  input  wire logic [23:0] module_sw_article,
  input  wire logic [7:0]  module_sw_index,
  input  wire logic [7:0]  module_prod_day,
  input  wire logic [7:0]  module_prod_month,
  input  wire logic [7:0]  module_prod_year,
  input  wire logic [31:0] module_serial,
  input  wire logic [23:0] module_hw_article,
  input  wire logic [7:0]  module_hw_index,
  input  wire logic [23:0] module_unit_article,
  input  wire logic [7:0]  module_unit_index,
  input  wire logic [7:0]  extra_error_info4,
  input  wire logic [7:0]  error_state_num,
  input  wire logic [7:0]  temp_celsius,
  // pins, asynchronous
  input  wire logic        fault_active,
  input  wire logic        gas_pressure_min_switch,
  input  wire logic        closure_proof_valve1,
  input  wire logic        closure_proof_valve2,
  input  wire logic        start_release,
  input  wire logic        stepped_second_valve_on,
  input  wire logic        main_burner_on,
  input  wire logic        auxiliary_input_on,
  input  wire logic        cooling_input_on,
  input  wire logic        cooling_air_press_err,
  input  wire logic        status_output_state,
  input  wire logic        high_temp_warning,
  input  wire logic        air_press_switch2,
  input  wire logic        fan_air_valve_output,
  // baud change request, same clock
  input  wire logic        cfg_req,
  input  wire logic [7:0]  cfg_func,
  input  wire logic [1:0]  cfg_baud,
  input  wire logic [1:0]  cfg_parity,
  output logic             cfg_ack,
  output logic             cfg_nak,
  // non-volatile store
  input  wire logic        nvm_valid,
  input  wire logic [1:0]  nvm_baud,
  input  wire logic [1:0]  nvm_parity,
  output logic             nvm_wr,
  output logic [1:0]       nvm_wr_baud,
  output logic [1:0]       nvm_wr_parity,
  // link settings
  output logic [1:0]       baud_sel,
  output logic [1:0]       parity_sel,
  output logic [15:0]      baud_div,
  input  wire logic [3:0]  dp_speed_code,
  output logic             dp_speed_ok
);

  // ****************************************
  // functions
  // ****************************************
  function automatic logic baud_ok(input logic [1:0] code);
    baud_ok = (code == bfrm_pkg::BFRM_BAUD_9600) ||
              (code == bfrm_pkg::BFRM_BAUD_19200) ||
              (code == bfrm_pkg::BFRM_BAUD_57600);
  endfunction : baud_ok

  function automatic logic parity_ok(input logic [1:0] code);
    parity_ok = (code != 2'b11);
  endfunction : parity_ok

  // clocks per bit, rounded down
  function automatic logic [15:0] div_of(input logic [1:0] code);
    case (code)
      bfrm_pkg::BFRM_BAUD_9600:
        div_of = 16'(`BFRM_CLK_HZ / `BFRM_BAUD_9600);
      bfrm_pkg::BFRM_BAUD_57600:
        div_of = 16'(`BFRM_CLK_HZ / `BFRM_BAUD_57600);
      default:
        div_of = 16'(`BFRM_CLK_HZ / `BFRM_BAUD_19200);
    endcase
  endfunction : div_of

  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NPIN = 14;
  logic [NPIN-1:0] pin_w;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic            fan_d_r;

  assign pin_w = {fan_air_valve_output, fault_active,
                  air_press_switch2, high_temp_warning,
                  status_output_state, cooling_air_press_err,
                  cooling_input_on, auxiliary_input_on,
                  main_burner_on, stepped_second_valve_on,
                  start_release, closure_proof_valve2,
                  closure_proof_valve1, gas_pressure_min_switch};

  always_ff @(posedge ref_clk) begin
    sync1_r <= pin_w;
    sync2_r <= sync1_r;
    fan_d_r <= sync2_r[13];
  end

  wire [11:0] status_s_w = sync2_r[11:0];
  wire        fault_s_w  = sync2_r[12];
  wire        fan_rise_w = sync2_r[13] & ~fan_d_r;

  // ****************************************
  // counter and temperature
  // ****************************************
  logic [31:0] cycle_cnt_r;
  logic [7:0]  temp_r;

  // wraps silently; 2^32 switchings outlast the unit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cycle_cnt_r <= 32'h0000_0000;
      temp_r      <= `BFRM_TEMP_BIAS;
    end else begin
      if (fan_rise_w)
        cycle_cnt_r <= cycle_cnt_r + 32'h0000_0001;
      temp_r <= temp_celsius + `BFRM_TEMP_BIAS;
    end
  end

  // ****************************************
  // word map
  // ****************************************
  logic [15:0] map_w [0:`BFRM_NUM_WORDS-1];

  assign map_w[0]  = {fault_s_w ? 8'h00 : unit_article_index,
                      unit_article_msb};
  assign map_w[1]  = module_sw_article[15:0];
  assign map_w[2]  = {module_sw_index, module_sw_article[23:16]};
  assign map_w[3]  = {module_prod_month, module_prod_day};
  assign map_w[4]  = {8'h00, module_prod_year};
  assign map_w[5]  = module_serial[15:0];
  assign map_w[6]  = module_serial[31:16];
  assign map_w[7]  = module_hw_article[15:0];
  assign map_w[8]  = {module_hw_index, module_hw_article[23:16]};
  assign map_w[9]  = module_unit_article[15:0];
  assign map_w[10] = {module_unit_index, module_unit_article[23:16]};
  assign map_w[11] = {8'h00, extra_error_info4};
  assign map_w[12] = {8'h00, error_state_num};
  assign map_w[13] = {4'h0, status_s_w};
  assign map_w[14] = {8'h00, temp_r};
  assign map_w[15] = cycle_cnt_r[15:0];
  assign map_w[16] = cycle_cnt_r[31:16];
  assign map_w[17] = 16'h0000;

  wire       in_range_w = (rd_addr >= `BFRM_ADDR_FIRST) &&
                          (rd_addr <= `BFRM_ADDR_LAST);
  wire [7:0] idx_w      = rd_addr - `BFRM_ADDR_FIRST;
  wire [15:0] rd_word_w = in_range_w ? map_w[idx_w[4:0]] : 16'h0000;

  // one-cycle read answer; writes are refused, never stored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_valid   <= 1'b0;
      rd_data    <= 16'h0000;
      rd_err     <= 1'b0;
      wr_refused <= 1'b0;
    end else begin
      rd_valid   <= rd_req;
      rd_data    <= rd_req ? rd_word_w : 16'h0000;
      rd_err     <= rd_req & ~in_range_w;
      wr_refused <= wr_req;
    end
  end

  // ****************************************
  // serial link settings
  // ****************************************
  logic load_done_r;

  wire cfg_good_w = cfg_req && (cfg_func == `BFRM_FC_SET_BAUD) &&
                    baud_ok(cfg_baud) && parity_ok(cfg_parity);
  wire cfg_bad_w  = cfg_req && !cfg_good_w;
  // stored value only trusted when both fields are legal
  wire nvm_take_w = !load_done_r && nvm_valid &&
                    baud_ok(nvm_baud) && parity_ok(nvm_parity);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      load_done_r   <= 1'b0;
      baud_sel      <= bfrm_pkg::BFRM_BAUD_19200;
      parity_sel    <= bfrm_pkg::BFRM_PAR_EVEN;
      baud_div      <= 16'(`BFRM_CLK_HZ / `BFRM_BAUD_19200);
      cfg_ack       <= 1'b0;
      cfg_nak       <= 1'b0;
      nvm_wr        <= 1'b0;
      nvm_wr_baud   <= bfrm_pkg::BFRM_BAUD_19200;
      nvm_wr_parity <= bfrm_pkg::BFRM_PAR_EVEN;
      dp_speed_ok   <= 1'b0;
    end else begin
      load_done_r <= 1'b1;
      cfg_ack     <= cfg_good_w;
      cfg_nak     <= cfg_bad_w;
      nvm_wr      <= cfg_good_w;
      dp_speed_ok <= dp_speed_code < `BFRM_DP_SPEED_COUNT;
      if (cfg_good_w) begin
        baud_sel      <= cfg_baud;
        parity_sel    <= cfg_parity;
        baud_div      <= div_of(cfg_baud);
        nvm_wr_baud   <= cfg_baud;
        nvm_wr_parity <= cfg_parity;
      end else if (nvm_take_w) begin
        baud_sel   <= nvm_baud;
        parity_sel <= nvm_parity;
        baud_div   <= div_of(nvm_baud);
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cfg_good;
    cfg_req && cfg_func == `BFRM_FC_SET_BAUD && cfg_baud != 2'b11 &&
    cfg_parity != 2'b11;
  endsequence

  sequence s_cfg_done;
    cfg_ack && nvm_wr && baud_sel == $past(cfg_baud) &&
    parity_sel == $past(cfg_parity) && nvm_wr_baud == $past(cfg_baud);
  endsequence

  property p_fault_index;
    rd_req && rd_addr == `BFRM_ADDR_UNIT_ART_UP && fault_s_w |=>
      rd_data[15:8] == 8'h00 && rd_data[7:0] == $past(unit_article_msb);
  endproperty
  a_fault_index: assert property (p_fault_index)
    else $error("article index not zero during fault");

  property p_sw_article_hi;
    rd_req && rd_addr == `BFRM_ADDR_SW_ART_HI |=>
      rd_data == {$past(module_sw_index), $past(module_sw_article[23:16])};
  endproperty
  a_sw_article_hi: assert property (p_sw_article_hi)
    else $error("word 43 layout wrong");

  property p_year_word;
    rd_req && rd_addr == `BFRM_ADDR_PROD_YEAR |=>
      rd_data == {8'h00, $past(module_prod_year)};
  endproperty
  a_year_word: assert property (p_year_word)
    else $error("word 45 layout wrong");

  property p_serial_hi;
    rd_req && rd_addr == `BFRM_ADDR_SERIAL_HI |=>
      rd_data == $past(module_serial[31:16]);
  endproperty
  a_serial_hi: assert property (p_serial_hi)
    else $error("serial high word wrong");

  property p_status_top;
    rd_req && rd_addr == `BFRM_ADDR_STATUS |=> rd_data[15:12] == 4'h0;
  endproperty
  a_status_top: assert property (p_status_top)
    else $error("unused status bits not zero");

  property p_status_pin;
    $stable(gas_pressure_min_switch)[*3] ##0
      (rd_req && rd_addr == `BFRM_ADDR_STATUS) |=>
      rd_data[0] == $past(gas_pressure_min_switch);
  endproperty
  a_status_pin: assert property (p_status_pin)
    else $error("gas pressure bit does not follow pin");

  property p_temp_bias;
    rd_req && rd_addr == `BFRM_ADDR_TEMP |=>
      rd_data == {8'h00, 8'($past(temp_celsius, 2) + `BFRM_TEMP_BIAS)};
  endproperty
  a_temp_bias: assert property (p_temp_bias)
    else $error("temperature bias wrong");

  property p_cycle_count;
    fan_rise_w |=> cycle_cnt_r == $past(cycle_cnt_r) + 32'h0000_0001;
  endproperty
  a_cycle_count: assert property (p_cycle_count)
    else $error("switching counter missed an edge");

  property p_rsvd_zero;
    rd_req && rd_addr == `BFRM_ADDR_RSVD |=> rd_data == 16'h0000 && !rd_err;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("word 58 not zero");

  property p_cfg_apply;
    s_cfg_good |=> s_cfg_done ##1 !nvm_wr || cfg_ack;
  endproperty
  a_cfg_apply: assert property (p_cfg_apply)
    else $error("baud change not applied and stored");

  property p_cfg_reject;
    load_done_r && cfg_req && cfg_func != `BFRM_FC_SET_BAUD |=>
      cfg_nak && !nvm_wr && $stable(baud_sel);
  endproperty
  a_cfg_reject: assert property (p_cfg_reject)
    else $error("foreign function code changed settings");

  property p_default_link;
    !load_done_r |-> baud_sel == bfrm_pkg::BFRM_BAUD_19200 &&
      parity_sel == bfrm_pkg::BFRM_PAR_EVEN;
  endproperty
  a_default_link: assert property (p_default_link)
    else $error("delivered default not 19200 even");

  property p_div_match;
    cfg_ack |-> baud_div == (baud_sel == 2'b00 ? 16'h1046 :
                             baud_sel == 2'b10 ? 16'h02b6 : 16'h0823);
  endproperty
  a_div_match: assert property (p_div_match)
    else $error("bit divisor does not match baud");

  property p_dp_speed;
    dp_speed_code > 4'h9 |=> !dp_speed_ok;
  endproperty
  a_dp_speed: assert property (p_dp_speed)
    else $error("illegal dp speed accepted");

  property p_out_of_range;
    rd_req && (rd_addr < `BFRM_ADDR_FIRST || rd_addr > `BFRM_ADDR_LAST) |=>
      rd_valid && rd_err && rd_data == 16'h0000;
  endproperty
  a_out_of_range: assert property (p_out_of_range)
    else $error("outside address not flagged");

  property p_wr_refused;
    wr_req && !cfg_req && load_done_r |=>
      wr_refused && $stable(baud_sel) && $stable(parity_sel);
  endproperty
  a_wr_refused: assert property (p_wr_refused)
    else $error("write not refused or settings moved");

  property p_nvm_restore;
    !load_done_r && nvm_valid && !cfg_req && nvm_baud != 2'b11 &&
      nvm_parity != 2'b11 |=>
      baud_sel == $past(nvm_baud) && parity_sel == $past(nvm_parity);
  endproperty
  a_nvm_restore: assert property (p_nvm_restore)
    else $error("stored settings not restored");

endmodule : bfrm_regmap

// ---- tb/bfrm_nvm_model.sv ----
// non-volatile settings store facing the register map
module bfrm_nvm_model (
  input  wire logic       ref_clk,
  input  wire logic       nvm_wr,
  input  wire logic [1:0] nvm_wr_baud,
  input  wire logic [1:0] nvm_wr_parity,
  output logic            nvm_valid,
  output logic [1:0]      nvm_baud,
  output logic [1:0]      nvm_parity
);
  timeunit 1ns;
  timeprecision 100ps;
  // erased until the first write; no reset so contents outlive the device
  initial begin
    nvm_valid  = 1'b0;
    nvm_baud   = 2'h3;
    nvm_parity = 2'h3;
  end
  always @(posedge ref_clk) begin
    if (nvm_wr === 1'b1) begin
      nvm_valid  <= 1'b1;
      nvm_baud   <= nvm_wr_baud;
      nvm_parity <= nvm_wr_parity;
    end
  end
endmodule : bfrm_nvm_model

// ---- tb/tb_top.sv ----
// self-checking bench for the burner fieldbus register map
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // signals
  // ****************************************
  logic        ref_clk, rst_n, rd_req, wr_req, cfg_req, fault_active;
  logic        fan_air_valve_output, rd_valid, rd_err, wr_refused;
  logic        cfg_ack, cfg_nak, nvm_wr, nvm_valid, dp_speed_ok;
  logic [7:0]  rd_addr, cfg_func, temp_celsius;
  logic [1:0]  cfg_baud, cfg_parity, nvm_baud, nvm_parity;
  logic [1:0]  nvm_wr_baud, nvm_wr_parity, baud_sel, parity_sel;
  logic [15:0] rd_data, baud_div;
  logic [3:0]  dp_speed_code;
  logic [11:0] st;
  logic [7:0]  unit_article_msb, unit_article_index, module_sw_index;
  logic [7:0]  module_prod_day, module_prod_month, module_prod_year;
  logic [7:0]  module_hw_index, module_unit_index, extra_error_info4;
  logic [7:0]  error_state_num;
  logic [23:0] module_sw_article, module_hw_article, module_unit_article;
  logic [31:0] module_serial;
  int          n_errors;
  int          tests_run;
  logic [15:0] exp_id [13] = '{16'ha2a1, 16'hb2b1, 16'hb4b3, 16'h0b1c,
    16'h0017, 16'hc2c1, 16'hc4c3, 16'hd2d1, 16'hd4d3, 16'he2e1, 16'he4e3,
    16'h005a, 16'h003c};

  bfrm_regmap dut (
    .ref_clk, .rst_n, .rd_req, .rd_addr, .rd_valid, .rd_data, .rd_err,
    .wr_req, .wr_refused, .unit_article_msb, .unit_article_index,
    .module_sw_article, .module_sw_index, .module_prod_day,
    .module_prod_month, .module_prod_year, .module_serial,
    .module_hw_article, .module_hw_index, .module_unit_article,
    .module_unit_index, .extra_error_info4, .error_state_num, .temp_celsius,
    .fault_active, .gas_pressure_min_switch(st[0]),
    .closure_proof_valve1(st[1]), .closure_proof_valve2(st[2]),
    .start_release(st[3]), .stepped_second_valve_on(st[4]),
    .main_burner_on(st[5]), .auxiliary_input_on(st[6]),
    .cooling_input_on(st[7]), .cooling_air_press_err(st[8]),
    .status_output_state(st[9]), .high_temp_warning(st[10]),
    .air_press_switch2(st[11]), .fan_air_valve_output,
    .cfg_req, .cfg_func, .cfg_baud, .cfg_parity, .cfg_ack, .cfg_nak,
    .nvm_valid, .nvm_baud, .nvm_parity, .nvm_wr, .nvm_wr_baud,
    .nvm_wr_parity, .baud_sel, .parity_sel, .baud_div, .dp_speed_code,
    .dp_speed_ok
  );

  bfrm_nvm_model nvm (
    .ref_clk, .nvm_wr, .nvm_wr_baud, .nvm_wr_parity, .nvm_valid,
    .nvm_baud, .nvm_parity
  );

  always #12.5 ref_clk = ~ref_clk;

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_cyc

  // all bus tasks start and end on a falling edge
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp,
                        input logic err);
    rd_addr = a;
    rd_req  = 1'b1;
    @(negedge ref_clk);
    rd_req = 1'b0;
    chk("rd_valid", 16'h0001, {15'h0, rd_valid});
    chk("rd_err", {15'h0, err}, {15'h0, rd_err});
    chk($sformatf("word %h", a), exp, rd_data);
    @(negedge ref_clk);
  endtask : rd_chk

  task automatic cfg(input logic [7:0] f, input logic [1:0] b,
                     input logic [1:0] p, input logic ok);
    cfg_func   = f;
    cfg_baud   = b;
    cfg_parity = p;
    cfg_req    = 1'b1;
    @(negedge ref_clk);
    cfg_req = 1'b0;
    chk("cfg_ack", {15'h0, ok}, {15'h0, cfg_ack});
    chk("cfg_nak", {15'h0, !ok}, {15'h0, cfg_nak});
    chk("nvm_wr", {15'h0, ok}, {15'h0, nvm_wr});
    @(negedge ref_clk);
  endtask : cfg

  task automatic chk_link(input logic [1:0] b, input logic [1:0] p);
    logic [15:0] d;
    d = (b == 2'h0) ? 16'h1046 : (b == 2'h1) ? 16'h0823 : 16'h02b6;
    chk("baud_sel", {14'h0, b}, {14'h0, baud_sel});
    chk("parity_sel", {14'h0, p}, {14'h0, parity_sel});
    chk("baud_div", d, baud_div);
  endtask : chk_link

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    $display("[ERR] watchdog expected end seen hang");
    end_sim();
  end

  initial begin
    {ref_clk, rst_n, rd_req, wr_req, cfg_req, fault_active} = 6'h0;
    {fan_air_valve_output, rd_addr, cfg_func, cfg_baud, cfg_parity} = 21'h0;
    {st, dp_speed_code} = 16'h0;
    temp_celsius = 8'h14;
    unit_article_msb    = 8'ha1;
    unit_article_index  = 8'ha2;
    module_sw_article   = 24'hb3b2b1;
    module_sw_index     = 8'hb4;
    module_prod_day     = 8'h1c;
    module_prod_month   = 8'h0b;
    module_prod_year    = 8'h17;
    module_serial       = 32'hc4c3c2c1;
    module_hw_article   = 24'hd3d2d1;
    module_hw_index     = 8'hd4;
    module_unit_article = 24'he3e2e1;
    module_unit_index   = 8'he4;
    extra_error_info4   = 8'h5a;
    error_state_num     = 8'h3c;
    n_errors = 0;
    tests_run = 0;
    wait_cyc(6);
    rst_n = 1'b1;
    wait_cyc(2);
    chk_link(2'h1, 2'h1);
    $display("test defaults done");
    for (int i = 0; i < 13; i++) begin
      rd_chk(8'h29 + 8'(i), exp_id[i], 1'b0);
    end
    fault_active = 1'b1;
    wait_cyc(3);
    rd_chk(8'h29, 16'h00a1, 1'b0);
    error_state_num = 8'hc3;
    rd_chk(8'h35, 16'h00c3, 1'b0);
    $display("test identity done");
    rd_chk(8'h37, 16'h0046, 1'b0);
    rd_chk(8'h3a, 16'h0000, 1'b0);
    rd_chk(8'h28, 16'h0000, 1'b1);
    rd_chk(8'h3b, 16'h0000, 1'b1);
    wr_req = 1'b1;
    @(negedge ref_clk);
    wr_req = 1'b0;
    chk("wr_refused", 16'h0001, {15'h0, wr_refused});
    wait_cyc(1);
    rd_chk(8'h29, 16'h00a1, 1'b0);
    $display("test map edges done");
    for (int i = 0; i < 12; i++) begin
      st = 12'h1 << i;
      wait_cyc(3);
      rd_chk(8'h36, 16'h1 << i, 1'b0);
    end
    st = 12'hfff;
    wait_cyc(3);
    rd_chk(8'h36, 16'h0fff, 1'b0);
    $display("test status done");
    rd_chk(8'h38, 16'h0000, 1'b0);
    repeat (3) begin
      fan_air_valve_output = 1'b1;
      wait_cyc(4);
      fan_air_valve_output = 1'b0;
      wait_cyc(4);
    end
    rd_chk(8'h38, 16'h0003, 1'b0);
    rd_chk(8'h39, 16'h0000, 1'b0);
    $display("test counter done");
    for (int b = 0; b < 3; b++) begin
      for (int p = 0; p < 3; p++) begin
        cfg(8'h41, 2'(b), 2'(p), 1'b1);
        chk_link(2'(b), 2'(p));
        chk("nvm", {12'h0, 2'(b), 2'(p)}, {12'h0, nvm_baud, nvm_parity});
      end
    end
    cfg(8'h42, 2'h0, 2'h0, 1'b0);
    cfg(8'h41, 2'h3, 2'h0, 1'b0);
    cfg(8'h41, 2'h0, 2'h3, 1'b0);
    chk_link(2'h2, 2'h2);
    $display("test link settings done");
    for (int c = 0; c < 16; c++) begin
      dp_speed_code = 4'(c);
      wait_cyc(1);
      chk("dp_speed_ok", {15'h0, c < 10}, {15'h0, dp_speed_ok});
    end
    $display("test dp speeds done");
    rst_n = 1'b0;
    wait_cyc(2);
    rst_n = 1'b1;
    wait_cyc(2);
    chk_link(2'h2, 2'h2);
    $display("test restore done");
    end_sim();
  end
endmodule : tb_top
